// ===== rtl/ocd_otp_ratio_config_decode.v
// What this block does
// R1 - The 3-bit bandwidth code gives a minimum locked bandwidth of 1 Hz doubling per step to 128 Hz.
// R2 - With the high-resolution format the ratio is unsigned 12.20 fixed point.
// R3 - With the high-multiplication format the ratio is unsigned 20.12 fixed point.
// R4 - Four user ratios, indexed zero to three, are kept in one-time storage, one per modal set.
// R5 - Every parameter besides the ratios is stored as separate single bits.
// R6 - The global format bit picks 20.12 when 0 and 12.20 when 1 for the indexed ratio.
// R7 - The two set-select mode pins choose the active modal set and its ratio.
// R8 - After reset release all stored bits are loaded into holding registers and then held constant until a reload is requested.
`timescale 1ns/1ps
`default_nettype none
`include "ocd_consts.vh"

module ocd_otp_ratio_config_decode #(
    parameter ADDR_W = 8
) (
    input  wire              hclk,
    input  wire              hresetn,
    input  wire              clk_en,
    input  wire              hsel,
    input  wire [ADDR_W-1:0] haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire              hready,
    input  wire [31:0]       hwdata,
    output reg  [31:0]       hrdata,
    output wire              hreadyout,
    output wire              hresp,
    input  wire [1:0]        mode_pin,
    output reg               config_valid,
    output reg  [1:0]        active_set,
    output reg  [31:0]       user_ratio,
    output reg  [39:0]       ratio_q20_20,
    output reg               ratio_format_sel,
    output reg  [1:0]        ratio_shift_sel,
    output reg  [1:0]        aux_source_sel,
    output reg               auto_shift_en,
    output reg  [2:0]        mode2_pin_function,
    output reg               pulse_skip_tolerance_en,
    output reg               unlock_flag_drive_cfg,
    output reg               output_on_unlock_en,
    output reg  [2:0]        ref_loop_bw_code,
    output reg  [7:0]        ref_loop_bw_hz
);

    // ============================================================
    // Loader states, one-hot so the status word can read the loading
    // flag straight from one state bit without a decoder.
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LOAD = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    // ============================================================
    // Storage and holding declarations. Storage models the fuse array; the
    // holding copies are what the decode reads, so the two can differ
    // until a reload.
    reg  [31:0]               store_ratio [0:3];
    reg  [`OCD_MOD_BITS-1:0]  store_modal [0:3];
    wire [`OCD_GLB_BITS-1:0]  store_global;
    reg  [31:0]               hold_ratio  [0:3];
    reg  [`OCD_MOD_BITS-1:0]  hold_modal  [0:3];
    reg  [`OCD_GLB_BITS-1:0]  hold_global;
    reg  [2:0]                state_reg;
    reg  [3:0]                load_idx_reg;
    reg  [1:0]                pin_s1_reg;
    reg  [1:0]                pin_s2_reg;
    reg  [1:0]                pin_s3_reg;
    reg  [1:0]                set_reg;
    reg                       dph_wr_reg;
    reg  [5:0]                dph_idx_reg;
    reg  [31:0]               rd_next;
    wire                      addr_ok;
    wire [5:0]                a_idx;
    wire                      wr_now;
    wire                      reload_req;
    integer                   k;

    // ============================================================
    // AHB-Lite slave: zero wait states, always OKAY; a frozen clock
    // enable stretches the phase so no transfer is lost.
    // Transfer size is not decoded: every register is one whole word,
    // so a narrower access would still act on the full word.
    assign hreadyout  = clk_en;
    assign hresp      = 1'b0;
    assign addr_ok    = hsel & hready & htrans[1];
    assign a_idx      = haddr[7:2];
    assign wr_now     = dph_wr_reg & clk_en;
    assign reload_req = wr_now & (dph_idx_reg == `OCD_IDX_CTRL) & hwdata[`OCD_CTRL_RELOAD];

    // Capture the address phase for the following data phase.
    // Only the write flag and word index are kept; read data is taken
    // in the address phase instead, so reads need no captured state.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_reg  <= 1'b0;
            dph_idx_reg <= 6'h00;
        end else if (clk_en) begin
            dph_wr_reg  <= addr_ok & hwrite;
            dph_idx_reg <= a_idx;
        end
    end

    // ============================================================
    // One-time storage: programming may only set bits, as a fuse does,
    // so a second write can never clear what was burned before.
    // The reset clearing is only a stand-in for an unburned array, so
    // each run can start from blank storage.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (k = 0; k < 4; k = k + 1) begin
                store_ratio[k] <= `OCD_BLANK_WORD; // R4
                store_modal[k] <= {`OCD_MOD_BITS{1'b0}};
            end
        end else if (wr_now) begin
            for (k = 0; k < 4; k = k + 1) begin
                if (dph_idx_reg == (`OCD_IDX_RATIO0 + k[5:0])) begin
                    store_ratio[k] <= store_ratio[k] | hwdata; // R4
                end
                if (dph_idx_reg == (`OCD_IDX_MODAL0 + k[5:0])) begin
                    store_modal[k] <= store_modal[k] | hwdata[`OCD_MOD_BITS-1:0]; // R5
                end
            end
        end
    end

    // Each global parameter bit is its own fuse cell.
    // A write can only burn cells whose data bit is one; zero bits
    // leave the cell as it was.
    genvar g;
    generate
        for (g = 0; g < `OCD_GLB_BITS; g = g + 1) begin : g_glb
            reg bit_reg;
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    bit_reg <= 1'b0;
                end else if (wr_now && (dph_idx_reg == `OCD_IDX_GLOBAL) && hwdata[g]) begin
                    bit_reg <= 1'b1; // R5
                end
            end
            assign store_global[g] = bit_reg;
        end
    endgenerate

    // ============================================================
    // Loader: walks the nine stored words into the holding registers
    // once after reset; holding values then stay fixed until a reload.
    // Storage written after the load is not seen by the decode until
    // software asks for a reload, which keeps the PLL settings steady.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= ST_IDLE;
            load_idx_reg <= 4'h0;
            config_valid <= 1'b0;
            hold_global  <= {`OCD_GLB_BITS{1'b0}};
            for (k = 0; k < 4; k = k + 1) begin
                hold_ratio[k] <= `OCD_BLANK_WORD;
                hold_modal[k] <= {`OCD_MOD_BITS{1'b0}};
            end
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg    <= ST_LOAD; // R8
                    load_idx_reg <= 4'h0;
                end
                ST_LOAD: begin
                    if (load_idx_reg < 4'h4) begin
                        hold_ratio[load_idx_reg[1:0]] <= store_ratio[load_idx_reg[1:0]]; // R8
                    end else if (load_idx_reg < `OCD_LOAD_LAST) begin
                        hold_modal[load_idx_reg[1:0]] <= store_modal[load_idx_reg[1:0]]; // R8
                    end else begin
                        hold_global <= store_global; // R8
                    end
                    if (load_idx_reg == `OCD_LOAD_LAST) begin
                        state_reg    <= ST_DONE;
                        config_valid <= 1'b1;
                    end else begin
                        load_idx_reg <= load_idx_reg + 4'h1;
                    end
                end
                ST_DONE: begin
                    if (reload_req) begin
                        state_reg    <= ST_LOAD;
                        load_idx_reg <= 4'h0;
                        config_valid <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Set-select pins come from outside: three stages, and a new
    // value is taken only once the second and third stages agree.
    // The pins are held levels, so the extra stage costs one cycle of
    // delay and filters a single-cycle glitch on either pin.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_reg <= 2'b00;
            pin_s2_reg <= 2'b00;
            pin_s3_reg <= 2'b00;
            set_reg    <= 2'b00;
        end else if (clk_en) begin
            pin_s1_reg <= mode_pin;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (pin_s2_reg == pin_s3_reg) begin
                set_reg <= pin_s3_reg; // R7
            end
        end
    end

    // ============================================================
    // Decode outputs, registered so the PLL sees clean levels. The ratio
    // is widened to a common 20.20 form so the PLL needs one datapath.
    // Every output but active_set is taken from the holding copies, never straight from
    // storage, so a fuse write cannot disturb a running PLL.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_set              <= 2'b00;
            user_ratio              <= `OCD_BLANK_WORD;
            ratio_q20_20            <= 40'h00_0000_0000;
            ratio_format_sel        <= `OCD_FMT_HIGH_MULT;
            ratio_shift_sel         <= 2'b00;
            aux_source_sel          <= 2'b00;
            auto_shift_en           <= 1'b0;
            mode2_pin_function      <= 3'b000;
            pulse_skip_tolerance_en <= 1'b0;
            unlock_flag_drive_cfg   <= 1'b0;
            output_on_unlock_en     <= 1'b0;
            ref_loop_bw_code        <= 3'b000;
            ref_loop_bw_hz          <= `OCD_BW_BASE_HZ;
        end else if (clk_en) begin
            active_set       <= set_reg; // R7
            user_ratio       <= hold_ratio[set_reg]; // R7
            ratio_format_sel <= hold_global[`OCD_GLB_FORMAT]; // R6
            if (hold_global[`OCD_GLB_FORMAT] == `OCD_FMT_HIGH_RES) begin
                ratio_q20_20 <= {8'h00, hold_ratio[set_reg]}; // R2
            end else begin
                ratio_q20_20 <= {hold_ratio[set_reg], 8'h00}; // R3
            end
            ratio_shift_sel         <= hold_modal[set_reg][`OCD_MOD_SHIFT1:`OCD_MOD_SHIFT0];
            aux_source_sel          <= hold_modal[set_reg][`OCD_MOD_AUX1:`OCD_MOD_AUX0];
            auto_shift_en           <= hold_modal[set_reg][`OCD_MOD_AUTO];
            mode2_pin_function      <= hold_global[`OCD_GLB_M2F2:`OCD_GLB_M2F0]; // R5
            pulse_skip_tolerance_en <= hold_global[`OCD_GLB_SKIP];
            unlock_flag_drive_cfg   <= hold_global[`OCD_GLB_UNLDRV];
            output_on_unlock_en     <= hold_global[`OCD_GLB_OUTUNL];
            ref_loop_bw_code        <= hold_global[`OCD_GLB_BW2:`OCD_GLB_BW0];
            ref_loop_bw_hz          <= `OCD_BW_BASE_HZ << hold_global[`OCD_GLB_BW2:`OCD_GLB_BW0]; // R1
        end
    end

    // ============================================================
    // Read mux: storage reads back the fuse state, other words show
    // the loader and decode state; unmapped words read zero.
    // Reading storage shows what is burned even before a reload, which
    // lets software verify a write before it commits it.
    always @* begin
        rd_next = 32'h0000_0000;
        case (a_idx)
            6'h00, 6'h01, 6'h02, 6'h03: begin
                rd_next = store_ratio[a_idx[1:0]];
            end
            6'h04, 6'h05, 6'h06, 6'h07: begin
                rd_next = {27'h000_0000, store_modal[a_idx[1:0]]};
            end
            `OCD_IDX_GLOBAL: begin
                rd_next = {22'h00_0000, store_global};
            end
            `OCD_IDX_STATUS: begin
                rd_next[`OCD_STS_VALID]   = config_valid;
                rd_next[`OCD_STS_LOADING] = state_reg[1];
                rd_next[`OCD_STS_SET1:`OCD_STS_SET0] = active_set;
            end
            `OCD_IDX_ACTIVE: begin
                rd_next = user_ratio;
            end
            `OCD_IDX_BW_HZ: begin
                rd_next = {24'h00_0000, ref_loop_bw_hz};
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    // Read data is latched in the address phase and stands in the data phase.
    // Taking it a cycle early keeps the data phase free of the read mux,
    // and the value stands until the next read is accepted.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && addr_ok && !hwrite) begin
            hrdata <= rd_next;
        end
    end

endmodule // ocd_otp_ratio_config_decode
`default_nettype wire

// ===== pkg/ocd_consts.vh
`ifndef OCD_CONSTS_VH
`define OCD_CONSTS_VH

// ============================================================
// Register byte offsets on the AHB-Lite slave.
`define OCD_OFS_RATIO0      8'h00
`define OCD_OFS_RATIO1      8'h04
`define OCD_OFS_RATIO2      8'h08
`define OCD_OFS_RATIO3      8'h0C
`define OCD_OFS_MODAL0      8'h10
`define OCD_OFS_MODAL1      8'h14
`define OCD_OFS_MODAL2      8'h18
`define OCD_OFS_MODAL3      8'h1C
`define OCD_OFS_GLOBAL      8'h20
`define OCD_OFS_CTRL        8'h24
`define OCD_OFS_STATUS      8'h28
`define OCD_OFS_ACTIVE      8'h2C
`define OCD_OFS_BW_HZ       8'h30

// ============================================================
// Word indices of the register offsets above.
`define OCD_IDX_RATIO0      6'h00
`define OCD_IDX_MODAL0      6'h04
`define OCD_IDX_GLOBAL      6'h08
`define OCD_IDX_CTRL        6'h09
`define OCD_IDX_STATUS      6'h0A
`define OCD_IDX_ACTIVE      6'h0B
`define OCD_IDX_BW_HZ       6'h0C

// ============================================================
// Modal word field positions, one bit each.
`define OCD_MOD_SHIFT0      0
`define OCD_MOD_SHIFT1      1
`define OCD_MOD_AUX0        2
`define OCD_MOD_AUX1        3
`define OCD_MOD_AUTO        4
`define OCD_MOD_BITS        5

// ============================================================
// Global word field positions; the two 3-bit fields give only their end bits.
`define OCD_GLB_SKIP        0
`define OCD_GLB_UNLDRV      1
`define OCD_GLB_OUTUNL      2
`define OCD_GLB_FORMAT      3
`define OCD_GLB_M2F0        4
`define OCD_GLB_M2F2        6
`define OCD_GLB_BW0         7
`define OCD_GLB_BW2         9
`define OCD_GLB_BITS        10

// ============================================================
// Control and status bit positions, reset values and counts.
`define OCD_CTRL_RELOAD     0
`define OCD_STS_VALID       0
`define OCD_STS_LOADING     1
`define OCD_STS_SET0        2
`define OCD_STS_SET1        3
`define OCD_BLANK_WORD      32'h0000_0000
`define OCD_LOAD_LAST       4'h8
`define OCD_BW_BASE_HZ      8'h01
`define OCD_FMT_HIGH_MULT   1'b0
`define OCD_FMT_HIGH_RES    1'b1

`endif

// ===== dv/ocd_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocd_consts.vh"

// ============================================================
// Port checker for the configuration loader.
module ocd_sva #(
    parameter ADDR_W = 8
) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              clk_en,
    input wire logic              hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic [1:0]        mode_pin,
    input wire logic              config_valid,
    input wire logic [1:0]        active_set,
    input wire logic [31:0]       user_ratio,
    input wire logic [39:0]       ratio_q20_20,
    input wire logic              ratio_format_sel,
    input wire logic [2:0]        mode2_pin_function,
    input wire logic [2:0]        ref_loop_bw_code,
    input wire logic [7:0]        ref_loop_bw_hz
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Decoded outputs land one edge after valid rises, so they are judged only later.
    sequence s_steady;
        config_valid [*3];
    endsequence
    sequence s_rd(a);
        hsel && hready && htrans[1] && !hwrite && clk_en && haddr == a;
    endsequence

    a_bw_decode: assert property (s_steady |-> ref_loop_bw_hz == 8'h01 << ref_loop_bw_code)
        else $error("bandwidth value does not follow its code");
    a_fmt_res: assert property (s_steady ##0 ($stable(user_ratio) && ratio_format_sel)
        |-> ratio_q20_20 == {8'h00, user_ratio}) else $error("12.20 scaling wrong");
    a_fmt_mult: assert property (s_steady ##0 ($stable(user_ratio) && !ratio_format_sel)
        |-> ratio_q20_20 == {user_ratio, 8'h00}) else $error("20.12 scaling wrong");
    a_hold_cfg: assert property (s_steady |-> $stable(ref_loop_bw_code)
        && $stable(ratio_format_sel) && $stable(mode2_pin_function)) else $error("held bits moved");
    a_set_pins: assert property ((config_valid && clk_en && $stable(mode_pin)) [*6]
        |-> active_set == mode_pin) else $error("active set does not follow pins");
    a_active_rd: assert property (s_rd(`OCD_OFS_ACTIVE) |=> hrdata == $past(user_ratio))
        else $error("active ratio read wrong");
    a_status_rd: assert property (s_rd(`OCD_OFS_STATUS) |=> hrdata[0] == $past(config_valid)
        && hrdata[3:2] == $past(active_set)) else $error("status read wrong");
    a_reload_len: assert property ($fell(config_valid) |-> !config_valid [*8] ##1 !config_valid
        ##1 config_valid) else $error("reload length wrong");
    a_bus_resp: assert property (hresp == 1'b0 && hreadyout == clk_en)
        else $error("bus response wrong");
endmodule // ocd_sva

`default_nettype wire

// ===== dv/ocd_otp_ratio_config_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocd_consts.vh"

// ============================================================
// Self-checking bench that programs storage over AHB-Lite.
module ocd_otp_ratio_config_decode_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0]  mode_pin = 2'b00;
    wire  logic [31:0] hrdata, user_ratio;
    wire  logic [39:0] ratio_q20_20;
    wire  logic [7:0]  ref_loop_bw_hz;
    wire  logic [2:0]  mode2_pin_function, ref_loop_bw_code;
    wire  logic [1:0]  active_set, ratio_shift_sel, aux_source_sel;
    wire  logic        hready, hresp, config_valid, ratio_format_sel, auto_shift_en;
    wire  logic        pulse_skip_tolerance_en, unlock_flag_drive_cfg, output_on_unlock_en;
    int          errors = 0;
    int          num_checks = 0;
    logic [31:0] ratio [4] = '{32'h0013_A92A, 32'h1000_0000, 32'h3200_0000, 32'h2DF5_E208};
    logic [4:0]  modal [4] = '{5'h11, 5'h0A, 5'h07, 5'h1C};

    // The single slave's ready is the bus ready; hsize is fixed at a whole word.
    ocd_otp_ratio_config_decode i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .mode_pin(mode_pin), .config_valid(config_valid), .active_set(active_set),
        .user_ratio(user_ratio), .ratio_q20_20(ratio_q20_20),
        .ratio_format_sel(ratio_format_sel), .ratio_shift_sel(ratio_shift_sel),
        .aux_source_sel(aux_source_sel), .auto_shift_en(auto_shift_en),
        .mode2_pin_function(mode2_pin_function),
        .pulse_skip_tolerance_en(pulse_skip_tolerance_en),
        .unlock_flag_drive_cfg(unlock_flag_drive_cfg),
        .output_on_unlock_en(output_on_unlock_en),
        .ref_loop_bw_code(ref_loop_bw_code), .ref_loop_bw_hz(ref_loop_bw_hz));

    // A 4 ns clock.
    always #2 hclk = ~hclk;

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask

    // One single transfer; entered just after an edge, and the bus is never assumed quick.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
        q = hrdata;
        if (hready !== 1'b1) begin
            errors++;
            test_done();
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        chk(what, 40'(exp), 40'(q));
    endtask

    task wait_cv(input logic lvl);
        int n;
        n = 0;
        while (config_valid !== lvl && n < 60) begin @(posedge hclk); n++; end
        if (config_valid !== lvl) begin
            errors++;
            test_done();
        end
    endtask

    // Fuse writes reach the outputs only through a reload, so each scenario that writes storage runs one.
    task reload;
        wr(`OCD_OFS_CTRL, 32'h0000_0001);
        wait_cv(1'b0);
        wait_cv(1'b1);
        repeat (3) @(posedge hclk);
    endtask

    task set_mode(input logic [1:0] s);
        mode_pin <= s;
        repeat (7) @(posedge hclk);
    endtask

    task t_reset;
        repeat (4) @(posedge hclk);
        chk("bw_hz in reset", 40'h00_0000_0001, 40'(ref_loop_bw_hz));
        chk("valid in reset", 40'h00_0000_0000, 40'(config_valid));
        hresetn <= 1'b1;
        wait_cv(1'b1);
        repeat (3) @(posedge hclk);
        rd("status", `OCD_OFS_STATUS, 32'h0000_0001);
        rd("unmapped", 8'h3C, 32'h0000_0000);
        chk("blank ratio", 40'h00_0000_0000, 40'(user_ratio));
        $display("t_reset done");
    endtask

    task t_sets;
        for (int s = 0; s < 4; s++) begin
            wr(8'(`OCD_OFS_RATIO0 + 4 * s), ratio[s]);
            wr(8'(`OCD_OFS_MODAL0 + 4 * s), 32'(modal[s]));
        end
        wr(`OCD_OFS_GLOBAL, 32'h0000_0155);
        chk("ratio before reload", 40'h00_0000_0000, 40'(user_ratio));
        rd("stored ratio2", `OCD_OFS_RATIO2, ratio[2]);
        reload();
        chk("globals", 40'h00_0002_D204, 40'({mode2_pin_function, pulse_skip_tolerance_en,
            unlock_flag_drive_cfg, output_on_unlock_en, ratio_format_sel, ref_loop_bw_code,
            ref_loop_bw_hz}));
        for (int s = 0; s < 4; s++) begin
            set_mode(2'(s));
            chk("active set", 40'(s), 40'(active_set));
            chk("ratio", 40'(ratio[s]), 40'(user_ratio));
            chk("q20 mult", {ratio[s], 8'h00}, ratio_q20_20);
            chk("modal", 40'(modal[s]), 40'({auto_shift_en, aux_source_sel, ratio_shift_sel}));
            rd("active reg", `OCD_OFS_ACTIVE, ratio[s]);
        end
        $display("t_sets done");
    endtask

    task t_format;
        wr(`OCD_OFS_GLOBAL, 32'h0000_0008);
        clk_en <= 1'b0;
        mode_pin <= 2'b01;
        repeat (7) @(posedge hclk);
        chk("format before reload", 40'h00_0000_0000, 40'(ratio_format_sel));
        chk("set frozen", 40'h00_0000_0003, 40'(active_set));
        clk_en <= 1'b1;
        @(posedge hclk);
        reload();
        chk("set after freeze", 40'h00_0000_0001, 40'(active_set));
        chk("format after reload", 40'h00_0000_0001, 40'(ratio_format_sel));
        for (int s = 0; s < 4; s++) begin
            set_mode(2'(s));
            chk("q20 res", 40'(ratio[s]), ratio_q20_20);
        end
        $display("t_format done");
    endtask

    // Storage bits only ever set, so each code starts from a fresh reset.
    task t_bw;
        for (int c = 0; c < 8; c++) begin
            hresetn <= 1'b0;
            repeat (4) @(posedge hclk);
            hresetn <= 1'b1;
            wait_cv(1'b1);
            wr(`OCD_OFS_GLOBAL, 32'(c) << 7);
            reload();
            chk("bw code", 40'(c), 40'(ref_loop_bw_code));
            chk("bw hz", 40'(1 << c), 40'(ref_loop_bw_hz));
            rd("bw reg", `OCD_OFS_BW_HZ, 32'(1 << c));
        end
        $display("t_bw done");
    endtask

    initial begin
        t_reset();
        t_sets();
        t_format();
        t_bw();
        test_done();
    end
endmodule // ocd_otp_ratio_config_decode_tb

bind ocd_otp_ratio_config_decode ocd_sva #(.ADDR_W(ADDR_W)) i_sva (.hclk(hclk),
    .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mode_pin(mode_pin), .config_valid(config_valid), .active_set(active_set),
    .user_ratio(user_ratio), .ratio_q20_20(ratio_q20_20), .ratio_format_sel(ratio_format_sel),
    .mode2_pin_function(mode2_pin_function), .ref_loop_bw_code(ref_loop_bw_code),
    .ref_loop_bw_hz(ref_loop_bw_hz));

`default_nettype wire
